//--- bench/seqt_bench.sv
/*
 * Self-checking bench for the sequence timing block and its incrementer.
 * Assumes one 20 MHz clock and that the four phases come from the block's
 * own divider, so all expectations are counted in system clocks.
 */
`timescale 1ns/100ps

module sequence_timing_and_incrementer_bench
    import seqt_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk, rst_n, master_clear, chain_enable, memory_ready;
    logic        run_enable, req_second, req_third, req_fourth;
    logic        incr_clear_req, seq_fetch, increment_select_ff;
    logic        second_seq_enable_ff, third_seq_enable_ff, fourth_seq_enable_ff;
    logic [8:0]  dec_fetch, dec_second, dec_third, dec_fourth, addr_stage;
    logic [8:0]  stage_ff, cmd_clear_ff, cmd_load_ff, load_seen;
    logic [8:0]  to_operand_ff, to_pc_ff, to_shift_ff;
    logic [8:0]  clr_d1, clr_d2, clr_d3;     // Clear strobe history
    logic [1:0]  phase_ff, ph_d1, ph_d2, ph_d3; // Phase history
    logic [14:0] instr_word, instr_reg_ff;
    int          miscompares, tests_run, n;
    // Rows: address, plus-one select, expected true output
    localparam logic [18:0] ROWS [6] = '{{9'h000, 1'b0, 9'h000}, {9'h1ff, 1'b0, 9'h1ff},
        {9'h15f, 1'b1, 9'h160}, {9'h0ff, 1'b1, 9'h100}, {9'h1ff, 1'b1, 9'h000},
        {9'h0fe, 1'b1, 9'h0ff}};

    // Clock: 50 ns period
    always #25 clk = ~clk;

    seqt_sequencer dut (.clk(clk), .rst_n(rst_n), .master_clear(master_clear),
        .chain_enable(chain_enable), .memory_ready(memory_ready), .run_enable(run_enable),
        .req_second(req_second), .req_third(req_third), .req_fourth(req_fourth),
        .incr_clear_req(incr_clear_req), .dec_fetch(dec_fetch), .dec_second(dec_second),
        .dec_third(dec_third), .dec_fourth(dec_fourth), .instr_word(instr_word),
        .addr_stage(addr_stage), .phase_ff(phase_ff), .stage_ff(stage_ff),
        .seq_fetch(seq_fetch), .second_seq_enable_ff(second_seq_enable_ff),
        .third_seq_enable_ff(third_seq_enable_ff), .fourth_seq_enable_ff(fourth_seq_enable_ff),
        .increment_select_ff(increment_select_ff), .cmd_clear_ff(cmd_clear_ff),
        .cmd_load_ff(cmd_load_ff), .instr_reg_ff(instr_reg_ff), .to_operand_ff(to_operand_ff),
        .to_pc_ff(to_pc_ff), .to_shift_ff(to_shift_ff));

    // ------------------------------------------------------------------
    // Compare tasks and closing
    // ------------------------------------------------------------------
    task chk_vec(input logic [14:0] got, input logic [14:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_vec

    task chk_bit(input logic got, input logic exp);
        chk_vec({14'h0000, got}, {14'h0000, exp});
    endtask : chk_bit

    task end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // Load phase expected for a one-hot load strobe
    function automatic logic [1:0] exp_ph(input logic [8:0] l);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < 9; i++)
            if (l[i])
                r = LOAD_PH_TBL[2*i +: 2];
        return r;
    endfunction : exp_ph

    // Walk one chain run: stage timing and which stages issued loads
    task run_chain(input logic [8:0] loads);
        for (n = 0; n < 60 && stage_ff !== 9'h001; n++)
            @(negedge clk);
        chk_bit(increment_select_ff, 1'b1);
        for (int s = 0; s < 9; s++)
        begin
            chk_vec(stage_ff, 9'h001 << s);
            repeat (12) @(negedge clk);
        end
        chk_vec(load_seen, loads);
    endtask : run_chain

    // ------------------------------------------------------------------
    // Strobe monitor: clear one phase ahead of every load
    // ------------------------------------------------------------------
    // Sampled at the falling edge so every register update has settled
    always @(negedge clk)
    begin
        if (cmd_load_ff !== 9'h000)
        begin
            chk_vec(cmd_load_ff, clr_d3);
            chk_vec(phase_ff, {ph_d3 + 2'h1});
            chk_vec(phase_ff, exp_ph(cmd_load_ff));
        end
        chk_bit($onehot0({second_seq_enable_ff, third_seq_enable_ff,
                          fourth_seq_enable_ff}), 1'b1);
        load_seen = load_seen | cmd_load_ff;
        {clr_d3, clr_d2, clr_d1} = {clr_d2, clr_d1, cmd_clear_ff};
        {ph_d3, ph_d2, ph_d1} = {ph_d2, ph_d1, phase_ff};
    end

    // Watchdog: three runs take about 300 clocks
    initial
    begin
        repeat (3000) @(posedge clk);
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {clk, rst_n, master_clear, run_enable, req_second, req_third} = 6'h00;
        {req_fourth, incr_clear_req} = 2'h0;
        {chain_enable, memory_ready} = 2'h3;
        {dec_fetch, dec_second, dec_third, dec_fourth} = 36'h0;
        {addr_stage, instr_word} = 24'h0;
        {clr_d1, clr_d2, clr_d3, load_seen, ph_d1, ph_d2, ph_d3} = 42'h0;
        miscompares = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_bit(seq_fetch, 1'b1);
        chk_vec({stage_ff, second_seq_enable_ff, third_seq_enable_ff, fourth_seq_enable_ff},
                15'h0000);
        // Fetch run; two requests at once, only the second may latch
        @(posedge clk);
        {addr_stage, instr_word} <= {9'h15f, 15'h2a5c};
        {dec_fetch, dec_second, dec_third} <= {9'h0f7, 9'h108, 9'h1ff};
        {req_second, req_third, run_enable} <= 3'h7;
        run_chain(9'h0f7);
        for (n = 0; n < 40 && second_seq_enable_ff !== 1'b1; n++)
            @(negedge clk);
        chk_vec({second_seq_enable_ff, third_seq_enable_ff, fourth_seq_enable_ff, seq_fetch},
                15'h0008);
        chk_vec(instr_reg_ff, 15'h2a5c);
        chk_vec(to_pc_ff, 9'h160);
        chk_vec(to_operand_ff, 9'h160);
        chk_vec(to_shift_ff, 9'h09f);
        // Plus-one rows through the block, chain held idle meanwhile
        @(posedge clk);
        run_enable <= 1'b0;
        for (int i = 2; i < 6; i++)
        begin
            @(posedge clk);
            addr_stage <= ROWS[i][18:10];
            @(posedge clk);
            @(negedge clk);
            chk_bit(increment_select_ff, ROWS[i][9]);
            chk_vec(to_pc_ff, ROWS[i][8:0]);
            chk_vec(to_shift_ff, {~ROWS[i][8:0]});
        end
        @(posedge clk);
        {addr_stage, run_enable} <= {9'h15f, 1'b1};
        // Second run: instruction register must hold its word
        @(posedge clk);
        {instr_word, req_second} <= {15'h1111, 1'b0};
        load_seen = 9'h000;
        run_chain(9'h108);
        @(negedge clk);
        chk_bit(second_seq_enable_ff, 1'b0);
        for (n = 0; n < 40 && third_seq_enable_ff !== 1'b1; n++)
            @(negedge clk);
        chk_vec({second_seq_enable_ff, third_seq_enable_ff, fourth_seq_enable_ff},
                15'h0002);
        chk_vec(instr_reg_ff, 15'h2a5c);
        // Third run: drop to plus-zero mid-run, then master clear
        @(posedge clk);
        req_third <= 1'b0;
        for (n = 0; n < 60 && stage_ff !== 9'h004; n++)
            @(negedge clk);
        @(posedge clk);
        incr_clear_req <= 1'b1;
        @(posedge clk);
        incr_clear_req <= 1'b0;
        repeat (4) @(negedge clk);
        chk_bit(increment_select_ff, 1'b0);
        chk_vec(to_pc_ff, 9'h15f);
        chk_vec(to_shift_ff, 9'h0a0);
        @(posedge clk);
        {master_clear, run_enable} <= 2'h2;
        @(posedge clk);
        master_clear <= 1'b0;
        @(negedge clk);
        chk_vec({stage_ff, second_seq_enable_ff, third_seq_enable_ff, fourth_seq_enable_ff},
                15'h0000);
        chk_bit(seq_fetch, 1'b1);
        // Plus-zero rows: select stays cleared, chain stays idle
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            addr_stage <= ROWS[i][18:10];
            @(posedge clk);
            @(negedge clk);
            chk_bit(increment_select_ff, ROWS[i][9]);
            chk_vec(to_operand_ff, ROWS[i][8:0]);
            chk_vec(to_shift_ff, {~ROWS[i][8:0]});
        end
        end_sim;
    end

endmodule : sequence_timing_and_incrementer_bench

//--- include/seqt_pkg.sv
/*
 * Constants shared by the sequence timing block and its address incrementer:
 * phase codes, stage count, per-stage load phases and timing figures.
 * Assumes a single 20 MHz system clock from which all slower rates derive.
 */
package seqt_pkg;

    // ------------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;     // System clock period
    localparam int CHAIN_RUN_NS  = 6400;   // One full run of the timing chain
    localparam int NUM_STAGES    = 9;      // Stages in the timing chain
    localparam int NUM_PHASES    = 4;      // Master clock phases per cycle
    // Longest phase length that still fits the run: rounds down
    localparam int PHASE_CLKS    = CHAIN_RUN_NS / (NUM_STAGES * NUM_PHASES * CLK_PERIOD_NS);
    localparam int ADDR_W        = 9;      // Incrementer width
    localparam int INSTR_W       = 15;     // Instruction word width

    // ------------------------------------------------------------------
    // Master clock phase codes
    // ------------------------------------------------------------------
    localparam logic [1:0] PH1 = 2'h0;
    localparam logic [1:0] PH2 = 2'h1;
    localparam logic [1:0] PH3 = 2'h2;
    localparam logic [1:0] PH4 = 2'h3;

    // Load phase for each stage, stage 0 in the low bits; clear is the phase before.
    // Even stages are set in odd cycles and load on three, odd stages load on one.
    localparam logic [17:0] LOAD_PH_TBL = {PH3, PH1, PH3, PH1, PH3, PH1, PH3, PH1, PH3};

    // Named stages
    localparam int FETCH_IR_STAGE             = 1;  // Instruction register load
    localparam int FOURTH_CYCLE_TIMING_STAGE  = 3;  // Set in fourth cycle
    localparam int SEVENTH_TIMING_STAGE       = 6;  // Seventh stage of the chain
    localparam int THIRD_CYCLE_TIMING_STAGE   = 2;  // Set in third cycle

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] SEQ_RESET   = 3'h0;
    localparam logic [8:0] STAGE_RESET = 9'h000;

    // Timing chain states, one-hot
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_RUN  = 3'b010,
        SQ_XFER = 3'b100
    } seqt_chain_t;

endpackage : seqt_pkg

//--- logic/seqt_incrementer.sv
/*
 * Nine-bit plus-zero / plus-one address incrementer, one stage per bit.
 * Assumes its caller registers the outputs; the logic here is combinational.
 */
`timescale 1ns/100ps

module seqt_incrementer
    import seqt_pkg::*;
#(
    parameter int WIDTH = ADDR_W
)(
    input  wire logic [WIDTH-1:0] addr_in,      // Address staging register
    input  wire logic             plus_one,     // High adds one, low adds zero
    output logic      [WIDTH-1:0] true_out,     // To operand register and counter
    output logic      [WIDTH-1:0] comp_out      // Complement, to shift count
);

    // ------------------------------------------------------------------
    // Carry chain
    // ------------------------------------------------------------------
    logic [WIDTH:0] carry;                      // Carry into each stage

    assign carry[0] = plus_one;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_stage
            // Pass-through only without an incoming carry; else a zero absorbs it
            assign true_out[i]  = carry[i] ? ~addr_in[i] : addr_in[i]; // RULE2 RULE3
            assign carry[i + 1] = carry[i] & addr_in[i];
        end
    endgenerate

    // Top carry is dropped: no end-around path
    assign comp_out = ~true_out; // RULE1 RULE14

endmodule : seqt_incrementer

//--- logic/seqt_sequencer.sv
/*
 * Sequence timing chain, sequence enables, command strobes and the
 * registered incrementer outputs.
 * Assumes synchronous inputs, decode inputs stable across a stage and one
 * 20 MHz clock; the four master phases are derived by an internal divider.
 */
// Overview of operation
// RULE1: Plus-zero passes address, complement to shift count
// RULE2: Plus-one sets lowest zero, clears lower bits
// RULE3: Pass-through only without carry from below
// RULE4: Targets cleared on phase before their load
// RULE5: Third-cycle stage clears phase two, loads three
// RULE6: Fourth-cycle stage clears phase four, loads one
// RULE7: Cycle numbering starts at chain initiation
// RULE8: Three enable flip-flops, each with control flip-flop
// RULE9: Fetch enables when all three enables clear
// RULE10: Master clear zeroes enable and control flip-flops
// RULE11: Commands combine decode, sequence enable, stage time
// RULE12: Fetch sequence loads instruction register
// RULE13: Increment select: clear plus-zero, set plus-one
// RULE14: Nine-bit incrementer, top carry discarded
// RULE15: Nine stages, one run about 6.4 microseconds; the code's phases round down to 3 clocks, so a run is 5.4 microseconds
// RULE16: Chain end clears all three enable flip-flops
// RULE17: Four phases per master cycle time everything
// RULE18: At most one sequence enable set
`timescale 1ns/100ps

module seqt_sequencer
    import seqt_pkg::*;
#(
    parameter int STAGES = NUM_STAGES
)(
    input  wire logic               clk,                  // 20 MHz system clock
    input  wire logic               rst_n,                // Async reset, low active
    input  wire logic               master_clear,         // Synchronous master clear
    input  wire logic               chain_enable,         // Timing chain enabled
    input  wire logic               memory_ready,         // Memory section free
    input  wire logic               run_enable,           // Run permitted
    input  wire logic               req_second,           // Next sequence: second
    input  wire logic               req_third,            // Next sequence: third
    input  wire logic               req_fourth,           // Next sequence: fourth
    input  wire logic               incr_clear_req,       // Select plus-zero
    input  wire logic [STAGES-1:0]  dec_fetch,            // Decode terms, fetch
    input  wire logic [STAGES-1:0]  dec_second,           // Decode terms, second
    input  wire logic [STAGES-1:0]  dec_third,            // Decode terms, third
    input  wire logic [STAGES-1:0]  dec_fourth,           // Decode terms, fourth
    input  wire logic [INSTR_W-1:0] instr_word,           // Word read from memory
    input  wire logic [ADDR_W-1:0]  addr_stage,           // Address staging register
    output logic      [1:0]         phase_ff,             // Current master phase
    output logic      [STAGES-1:0]  stage_ff,             // Timing chain stages
    output logic                    seq_fetch,            // Fetch sequence enable
    output logic                    second_seq_enable_ff, // Second sequence enable
    output logic                    third_seq_enable_ff,  // Third sequence enable
    output logic                    fourth_seq_enable_ff, // Fourth sequence enable
    output logic                    increment_select_ff,  // Plus-one when set
    output logic      [STAGES-1:0]  cmd_clear_ff,         // Clear strobes per stage
    output logic      [STAGES-1:0]  cmd_load_ff,          // Load strobes per stage
    output logic      [INSTR_W-1:0] instr_reg_ff,         // Instruction register
    output logic      [ADDR_W-1:0]  to_operand_ff,        // Incrementer, true
    output logic      [ADDR_W-1:0]  to_pc_ff,             // Incrementer, true
    output logic      [ADDR_W-1:0]  to_shift_ff           // Incrementer, complement
);

    // ------------------------------------------------------------------
    // Phase divider
    // ------------------------------------------------------------------
    localparam logic [3:0] DIV_LAST = 4'(PHASE_CLKS - 1);

    logic [3:0] div_ff;          // Clocks within a phase
    logic [3:0] nxt_div;
    logic [1:0] nxt_phase;
    logic       phase_stb;       // One-cycle pulse in the last clock of a phase, before the new phase registers
    logic [1:0] ph_enter;        // Phase being entered

    // Enable pulse marks each phase boundary; phases run 1..4 in turn
    always_comb
    begin
        phase_stb = (div_ff == DIV_LAST);
        ph_enter  = phase_ff + 2'h1;
        nxt_div   = phase_stb ? 4'h0 : div_ff + 4'h1;
        nxt_phase = phase_stb ? ph_enter : phase_ff; // RULE17
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_ff   <= 4'h0;
            phase_ff <= PH1;
        end
        else
        begin
            div_ff   <= nxt_div;
            phase_ff <= nxt_phase;
        end
    end

    // ------------------------------------------------------------------
    // Timing chain and sequence enables
    // ------------------------------------------------------------------
    seqt_chain_t chain_ff;            // Chain state
    seqt_chain_t nxt_chain;
    logic [STAGES-1:0] nxt_stage;
    logic [2:0] ctl_ff;               // Control flip-flops: second, third, fourth
    logic [2:0] nxt_ctl;
    logic [2:0] en_ff;                // Enable flip-flops: second, third, fourth
    logic [2:0] nxt_en;
    logic       nxt_incr;
    logic       init_go;              // Chain initiated this cycle
    logic       chain_end;            // Last stage leaving
    logic [2:0] req_pick;             // Request reduced to at most one bit

    localparam logic [STAGES-1:0] STAGES_RESET_W = '0;

    assign second_seq_enable_ff = en_ff[0]; // RULE8
    assign third_seq_enable_ff  = en_ff[1];
    assign fourth_seq_enable_ff = en_ff[2];
    assign seq_fetch            = (en_ff == 3'h0); // RULE9

    // Chain steps on phase two entries; cycle one is the initiation cycle
    always_comb
    begin
        nxt_chain = chain_ff;
        nxt_stage = stage_ff;
        nxt_ctl   = ctl_ff;
        nxt_en    = en_ff;
        nxt_incr  = increment_select_ff;
        init_go   = 1'b0;
        chain_end = 1'b0;
        // Priority keeps the control set one-hot even if requests overlap
        req_pick  = req_second ? 3'b001 : req_third ? 3'b010 : req_fourth ? 3'b100 : 3'b000; // RULE18
        case (chain_ff)
            SQ_IDLE:
            begin
                // Initiation needs every condition and the phase two edge
                if (phase_stb && ph_enter == PH2 && chain_enable && memory_ready && run_enable)
                begin
                    init_go   = 1'b1;
                    nxt_stage = STAGES'(1); // RULE7
                    nxt_chain = SQ_RUN;
                end
            end
            SQ_RUN:
            begin
                if (ctl_ff == 3'h0)
                    nxt_ctl = req_pick;
                if (phase_stb && ph_enter == PH2)
                begin
                    nxt_stage = stage_ff << 1; // RULE15
                    if (stage_ff[STAGES-1])
                    begin
                        chain_end = 1'b1;
                        nxt_en    = 3'h0; // RULE16
                        nxt_chain = SQ_XFER;
                    end
                end
            end
            SQ_XFER:
            begin
                // Hand the chosen sequence over on the next phase one
                if (phase_stb && ph_enter == PH1)
                begin
                    nxt_en    = ctl_ff; // RULE8
                    nxt_ctl   = 3'h0;
                    nxt_chain = SQ_IDLE;
                end
            end
            default:
            begin
                nxt_chain = SQ_IDLE;
                nxt_stage = STAGES_RESET_W;
            end
        endcase
        // Clear request selects plus-zero; initiation wins over it
        if (incr_clear_req)
            nxt_incr = 1'b0; // RULE13
        if (init_go)
            nxt_incr = 1'b1; // RULE13
        if (master_clear)
        begin
            nxt_en    = SEQ_RESET; // RULE10
            nxt_ctl   = SEQ_RESET;
            nxt_stage = STAGES_RESET_W;
            nxt_chain = SQ_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chain_ff            <= SQ_IDLE;
            stage_ff            <= STAGES_RESET_W;
            ctl_ff              <= SEQ_RESET; // RULE10
            en_ff               <= SEQ_RESET;
            increment_select_ff <= 1'b0;
        end
        else
        begin
            chain_ff            <= nxt_chain;
            stage_ff            <= nxt_stage;
            ctl_ff              <= nxt_ctl;
            en_ff               <= nxt_en;
            increment_select_ff <= nxt_incr;
        end
    end

    // ------------------------------------------------------------------
    // Command strobes, instruction register and incrementer outputs
    // ------------------------------------------------------------------
    logic [STAGES-1:0]  dec_sel;      // Decode terms of the active sequence
    logic [STAGES-1:0]  nxt_clear;
    logic [STAGES-1:0]  nxt_load;
    logic [INSTR_W-1:0] nxt_ir;
    logic [ADDR_W-1:0]  inc_true;
    logic [ADDR_W-1:0]  inc_comp;

    seqt_incrementer #(
        .WIDTH    (ADDR_W)
    ) u_incr (
        .addr_in  (addr_stage),
        .plus_one (increment_select_ff),
        .true_out (inc_true),
        .comp_out (inc_comp)
    );

    // Only one stage is live, so each strobe fires once per stage window
    always_comb
    begin
        dec_sel = seq_fetch ? dec_fetch :
                  en_ff[0]  ? dec_second :
                  en_ff[1]  ? dec_third : dec_fourth; // RULE11
        for (int s = 0; s < STAGES; s++)
        begin
            // On a phase two edge the stage being set owns the strobe, so the
            // phase-two clear ahead of a phase-three load falls inside its own stage window
            nxt_clear[s] = phase_stb && (ph_enter == PH2 ? nxt_stage[s] : stage_ff[s]) &&
                           dec_sel[s] &&
                           ph_enter == LOAD_PH_TBL[2*s +: 2] - 2'h1; // RULE4 RULE5 RULE6
            nxt_load[s]  = phase_stb && (ph_enter == PH2 ? nxt_stage[s] : stage_ff[s]) &&
                           dec_sel[s] &&
                           ph_enter == LOAD_PH_TBL[2*s +: 2]; // RULE11
        end
        nxt_ir = instr_reg_ff;
        if (seq_fetch && nxt_clear[FETCH_IR_STAGE])
            nxt_ir = '0; // RULE4
        else if (seq_fetch && nxt_load[FETCH_IR_STAGE])
            nxt_ir = instr_word; // RULE12
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_clear_ff  <= STAGES_RESET_W;
            cmd_load_ff   <= STAGES_RESET_W;
            instr_reg_ff  <= '0;
            to_operand_ff <= '0;
            to_pc_ff      <= '0;
            to_shift_ff   <= '0;
        end
        else
        begin
            cmd_clear_ff  <= nxt_clear;
            cmd_load_ff   <= nxt_load;
            instr_reg_ff  <= nxt_ir;
            to_operand_ff <= inc_true; // RULE1
            to_pc_ff      <= inc_true;
            to_shift_ff   <= inc_comp; // RULE1
        end
    end

    // ------------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    localparam int PH_CLKS = PHASE_CLKS;   // Clocks from clear strobe to load strobe

    a_seq_onehot_sel: assert property ($onehot0(en_ff) && $onehot0(ctl_ff)) // RULE18
        else $error("more than one sequence enable or control set");
    a_fetch_when_clear: assert property (seq_fetch == !(second_seq_enable_ff ||
        third_seq_enable_ff || fourth_seq_enable_ff)) // RULE9
        else $error("fetch enable disagrees with enable flip-flops");
    a_master_clear_zero: assert property (master_clear |=> en_ff == 3'h0 && ctl_ff == 3'h0) // RULE10
        else $error("master clear left a sequence flip-flop set");
    a_chain_end_clear: assert property (chain_end && !master_clear |=> en_ff == 3'h0
        && chain_ff == SQ_XFER) // RULE16
        else $error("enables not cleared at chain end");
    a_third_cycle_phase: assert property (cmd_load_ff[THIRD_CYCLE_TIMING_STAGE] |->
        phase_ff == PH3 && $past(cmd_clear_ff[THIRD_CYCLE_TIMING_STAGE], PHASE_CLKS)) // RULE5
        else $error("third cycle stage not cleared on two and loaded on three");
    a_fourth_cycle_phase: assert property (cmd_clear_ff[FOURTH_CYCLE_TIMING_STAGE] |->
        phase_ff == PH4 ##PH_CLKS cmd_load_ff[FOURTH_CYCLE_TIMING_STAGE] || master_clear) // RULE6
        else $error("fourth cycle stage not cleared on four and loaded on one");
    a_incr_plus_zero: assert property (!increment_select_ff |=> to_pc_ff == $past(addr_stage)
        && to_shift_ff == ~$past(addr_stage)) // RULE1
        else $error("plus-zero output wrong");
    a_incr_plus_one: assert property (increment_select_ff |=>
        to_pc_ff == ADDR_W'($past(addr_stage) + 9'h001)) // RULE2 RULE14
        else $error("plus-one output wrong");
    a_init_select: assert property (init_go |=> increment_select_ff && stage_ff[0]) // RULE13
        else $error("initiation did not select plus-one");
    a_ir_fetch_only: assert property (!seq_fetch && !$past(seq_fetch) |=>
        $stable(instr_reg_ff)) // RULE12
        else $error("instruction register changed outside fetch");

    c_chain_end:   cover property (chain_end);
    c_second_seq:  cover property (second_seq_enable_ff && stage_ff[0]);
    c_carry_wrap:  cover property (increment_select_ff && addr_stage == 9'h1ff);
    c_ir_load:     cover property (seq_fetch && cmd_load_ff[FETCH_IR_STAGE]);

endmodule : seqt_sequencer
